/* File: rtl/bfg_pkg.sv */
// shared constants and carrier types of the boot flash section guard
package bfg_pkg;
    localparam int          ADDR_W         = 15;          // flash word address width
    localparam int          PAGE_LSB       = 7;           // words per page = 2**PAGE_LSB
    localparam logic [14:0] NO_READ_WHILE_WRITE_AREA_START     = 15'h7000;    // fixed read-while-write limit
    // boot section start per boot_size_fuses code, all inside the no-rww area
    localparam logic [14:0] BOOT_START_11  = 15'h7e00;
    localparam logic [14:0] BOOT_START_10  = 15'h7c00;
    localparam logic [14:0] BOOT_START_01  = 15'h7800;
    localparam logic [14:0] BOOT_START_00  = 15'h7000;
    localparam logic [1:0]  FUSE_DEFAULT   = 2'h0;
    localparam logic [3:0]  LOCK_ERASED    = 4'hf;        // all lock bits unprogrammed
    // lock vector layout
    localparam int          LK_APP_LO      = 0;
    localparam int          LK_APP_HI      = 1;
    localparam int          LK_BOOT_LO     = 2;
    localparam int          LK_BOOT_HI     = 3;
    // register map
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam int          CTRL_REENABLE  = 0;
    localparam int          CTRL_VEC_BOOT  = 1;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_HALT        = 1;
    localparam int          ST_FLASH       = 2;
    localparam int          ST_LOCK        = 4;
    localparam int          ST_FUSE        = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;

    typedef enum logic [1:0] {
        OP_BUF_LOAD,
        OP_ERASE,
        OP_WRITE,
        OP_LOCK_SET
    } bfg_op_e;

    typedef struct packed {
        bfg_op_e     op;
        logic [14:0] pc;       // word address the instruction was fetched from
        logic [14:0] target;   // word address from the pointer register
        logic [3:0]  data;     // lock bits to program, 0 programs
    } bfg_store_s;

    typedef struct packed {
        logic [14:0] pc;
        logic [14:0] addr;
    } bfg_load_s;
endpackage : bfg_pkg

/* File: rtl/bfg_guard.sv */
// boot flash section guard: store/load access control, stall and rww blocking
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - stores fetched from application section do nothing
// - boot code may store to any page
// - section boundary follows boot size fuses
// - rww-area programming leaves cpu running
// - no_read_while_write_area-area programming halts cpu throughout
// - boot section always inside no_read_while_write_area area
// - busy flag reads one while rww blocked
// - app and boot lock pairs independent
// - locks programmed by boot code or the pins, cleared by chip erase
// - general lock modes never restrict self-programming
// - lock pair all ones means unrestricted
// - app lower lock refuses app stores
// - app upper lock refuses boot reads of app
// - boot lower lock refuses boot stores
// - boot upper lock refuses app reads of boot
// - busy clears by reenable or buffer load
module bfg_guard
    import bfg_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  boot_size_fuses,
    input  wire logic        chip_erase,
    input  wire logic        ext_lock_valid,
    input  wire logic [3:0]  ext_lock_data,
    input  wire logic        store_valid,
    input  wire bfg_store_s  store_req,
    output logic             store_ready,
    output logic             store_done,
    output logic             store_refused,
    input  wire logic        load_valid,
    input  wire bfg_load_s   load_req,
    output logic             load_grant,
    output logic             load_refused,
    output logic             cpu_halt,
    output logic             rww_read_block,
    output logic             irq_suppress,
    output logic             flash_start,
    output bfg_op_e          flash_op,
    output logic [14:0]      flash_page,
    input  wire logic        flash_done
);
    typedef enum {ST_IDLE, ST_RUN} bfg_state_e;

    bfg_state_e  state_q;
    logic [1:0]  fuse_q;
    logic        fuse_taken_q;
    logic [3:0]  lock_q;
    logic        busy_q;
    logic        halt_q;
    logic        vec_boot_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [14:0] boot_start;
    logic        pc_boot;
    logic        tgt_boot;
    logic        tgt_no_read_while_write_area;
    logic        store_ok;
    logic        store_go;
    logic        prog_start;
    logic        reenable;
    logic        wr_fire;
    logic        ld_pc_boot;
    logic        ld_addr_boot;
    logic        ld_addr_rww;
    logic        ld_ok;

    // boot section start chosen by the strapped fuse code
    always_comb begin
        case (fuse_q)
            2'h3:    boot_start = BOOT_START_11;
            2'h2:    boot_start = BOOT_START_10;
            2'h1:    boot_start = BOOT_START_01;
            default: boot_start = BOOT_START_00;
        endcase
    end
    // all boot starts sit at or above the no_read_while_write_area limit, so boot implies no_read_while_write_area
    assign pc_boot  = (store_req.pc >= boot_start);
    assign tgt_boot = (store_req.target >= boot_start);
    assign tgt_no_read_while_write_area = (store_req.target >= NO_READ_WHILE_WRITE_AREA_START) | tgt_boot;
    // store permission: boot code only, then for erase and write the lower lock of the target section
    always_comb begin
        store_ok = pc_boot;
        case (store_req.op)
            OP_ERASE, OP_WRITE: begin
                if (tgt_boot) begin
                    store_ok = store_ok & lock_q[LK_BOOT_LO];
                end else begin
                    store_ok = store_ok & lock_q[LK_APP_LO];
                end
            end
            default: store_ok = store_ok;
        endcase
    end
    // a store is only taken while no erase or write is running
    assign store_ready = (state_q == ST_IDLE);
    assign store_go    = store_valid & store_ready & store_ok;
    assign prog_start  = store_go & (store_req.op inside {OP_ERASE, OP_WRITE});
    // fuses are straps: caught once by the first clocked edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_q       <= FUSE_DEFAULT;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_q       <= boot_size_fuses;
            fuse_taken_q <= 1'b1;
        end
    end
    // lock bits only move towards programmed; only reset and chip erase restore them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q <= LOCK_ERASED;
        end else if (chip_erase) begin
            lock_q <= LOCK_ERASED;
        end else begin
            if (store_go && store_req.op == OP_LOCK_SET) begin
                lock_q <= lock_q & store_req.data & (ext_lock_valid ? ext_lock_data
                                                                    : LOCK_ERASED);
            end else if (ext_lock_valid) begin
                lock_q <= lock_q & ext_lock_data;
            end
        end
    end

    // flash operation sequencer; page address latched at start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= ST_IDLE;
            flash_start <= 1'b0;
            flash_op    <= OP_BUF_LOAD;
            flash_page  <= '0;
            store_done  <= 1'b0;
        end else begin
            flash_start <= store_go;
            store_done  <= 1'b0;
            if (store_go) begin
                flash_op   <= store_req.op;
                flash_page <= store_req.target;
            end
            case (state_q)
                ST_IDLE: begin
                    if (prog_start) begin
                        state_q    <= ST_RUN;
                    end else if (store_go) begin
                        store_done <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (flash_done) begin
                        state_q    <= ST_IDLE;
                        store_done <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // refused stores answer in the next cycle and start nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_refused <= 1'b0;
        end else begin
            store_refused <= store_valid & store_ready & ~store_ok;
        end
    end
    // cpu stall covers the whole no_read_while_write_area operation; rww targets keep it running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= 1'b0;
        end else if (prog_start) begin
            halt_q <= tgt_no_read_while_write_area;
        end else if (state_q == ST_RUN && flash_done) begin
            halt_q <= 1'b0;
        end
    end
    assign cpu_halt = halt_q | (prog_start & tgt_no_read_while_write_area);
    // re-enable only counts once the flash is idle
    assign reenable = wr_fire & (awaddr_q == REG_CTRL) & wstrb_q[0]
                    & wdata_q[CTRL_REENABLE] & (state_q == ST_IDLE) & ~prog_start;
    // busy flag: a new rww start wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
        end else if (prog_start && !tgt_no_read_while_write_area) begin
            busy_q <= 1'b1;
        end else if (reenable || (store_go && store_req.op == OP_BUF_LOAD)) begin
            busy_q <= 1'b0;
        end
    end
    assign rww_read_block = busy_q;
    // load permission: rww blocking plus the upper lock of the other section
    assign ld_pc_boot   = (load_req.pc >= boot_start);
    assign ld_addr_boot = (load_req.addr >= boot_start);
    assign ld_addr_rww  = (load_req.addr < NO_READ_WHILE_WRITE_AREA_START);
    always_comb begin
        ld_ok = ~(ld_addr_rww & busy_q);
        if (ld_pc_boot && !ld_addr_boot) begin
            ld_ok = ld_ok & lock_q[LK_APP_HI];
        end else if (!ld_pc_boot && ld_addr_boot) begin
            ld_ok = ld_ok & lock_q[LK_BOOT_HI];
        end
    end

    // load answers are one-cycle pulses; no load is answered while halted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_grant   <= 1'b0;
            load_refused <= 1'b0;
        end else begin
            load_grant   <= load_valid & ~cpu_halt & ld_ok;
            load_refused <= load_valid & ~cpu_halt & ~ld_ok;
        end
    end

    // interrupts masked while running the section whose upper lock is set,
    // when the vectors live in the other section; only a limit, not a fix
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_suppress <= 1'b0;
        end else begin
            irq_suppress <= (vec_boot_q & ~ld_pc_boot & ~lock_q[LK_APP_HI])
                          | (~vec_boot_q & ld_pc_boot & ~lock_q[LK_BOOT_HI]);
        end
    end

    // write address and data are taken in either order, one write at a time
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
    assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write response and control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            vec_boot_q   <= 1'b0;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == REG_CTRL) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (wstrb_q[0]) begin
                        vec_boot_q <= wdata_q[CTRL_VEC_BOOT];
                    end
                end else if (awaddr_q == REG_STATUS) begin
                    s_axi_bresp <= RESP_OKAY;   // read-only, write ignored
                end else begin
                    s_axi_bresp <= RESP_DECERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel answers one cycle after the address is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= '0;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    REG_CTRL: begin
                        s_axi_rdata[CTRL_VEC_BOOT] <= vec_boot_q;
                    end
                    REG_STATUS: begin
                        s_axi_rdata[ST_BUSY]              <= busy_q;
                        s_axi_rdata[ST_HALT]              <= halt_q;
                        s_axi_rdata[ST_FLASH]             <= (state_q == ST_RUN);
                        s_axi_rdata[ST_LOCK +: 4]         <= lock_q;
                        s_axi_rdata[ST_FUSE +: 2]         <= fuse_q;
                    end
                    default: s_axi_rresp <= RESP_DECERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : bfg_guard

/* File: test/bfg_flash_model.sv */
// flash array stand-in: answers each erase or write start with a done pulse
`timescale 1ns/1ps
module bfg_flash_model
    import bfg_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       flash_start,
    input  wire bfg_op_e    flash_op,
    input  wire logic [7:0] lat,
    output logic            flash_done
);
    logic [7:0] cnt_q;

    // lat of 1 answers promptly, larger values keep the array busy longer
    always_ff @(posedge aclk) begin
        flash_done <= 1'b0;
        if (!aresetn) begin
            cnt_q <= 8'h00;
        end else if (flash_start && flash_op inside {OP_ERASE, OP_WRITE}) begin
            cnt_q <= lat;
        end else if (cnt_q == 8'h01) begin
            cnt_q      <= 8'h00;
            flash_done <= 1'b1;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : bfg_flash_model

/* File: test/bfg_guard_assertions.sv */
// concurrent checks on the section guard ports
`timescale 1ns/1ps
module bfg_guard_assertions
    import bfg_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       store_valid,
    input wire bfg_store_s store_req,
    input wire logic       store_ready,
    input wire logic       store_done,
    input wire logic       store_refused,
    input wire logic       load_valid,
    input wire bfg_load_s  load_req,
    input wire logic       load_grant,
    input wire logic       load_refused,
    input wire logic       cpu_halt,
    input wire logic       rww_read_block,
    input wire logic       flash_start,
    input wire bfg_op_e    flash_op,
    input wire logic       flash_done
);
    logic take;
    logic erw;
    logic boot_pc;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // the top boot start lies in the boot section whatever the fuse code
    assign take    = store_valid && store_ready;
    assign erw     = store_req.op inside {OP_ERASE, OP_WRITE};
    assign boot_pc = store_req.pc >= BOOT_START_11;

    app_store_ignored_a: assert property (take && store_req.pc < NO_READ_WHILE_WRITE_AREA_START
        |=> store_refused && !flash_start) else $error("app store went ahead");
    rww_keeps_running_a: assert property (take && boot_pc && erw
        && store_req.target < NO_READ_WHILE_WRITE_AREA_START
        |=> store_refused or (flash_start && !cpu_halt ##1 rww_read_block))
        else $error("rww program halted or not blocked");
    no_read_while_write_area_halts_cpu_a: assert property (take && boot_pc && erw
        && store_req.target >= NO_READ_WHILE_WRITE_AREA_START |=> store_refused || (cpu_halt && flash_start))
        else $error("no_read_while_write_area program without halt");
    halt_release_a: assert property ($fell(cpu_halt)
        |-> $past(flash_done) || store_refused) else $error("halt ended early");
    done_follows_a: assert property (flash_done |=> store_done)
        else $error("no done after flash");
    start_cause_a: assert property (flash_start |-> $past(take))
        else $error("start without store");
    busy_blocks_a: assert property (load_valid && !cpu_halt && rww_read_block
        && load_req.addr < NO_READ_WHILE_WRITE_AREA_START |=> load_refused) else $error("rww read while busy");
    load_answer_a: assert property (load_valid && !cpu_halt
        |=> load_grant ^ load_refused) else $error("load not answered once");
    halt_no_load_a: assert property (load_valid && cpu_halt
        |=> !load_grant && !load_refused) else $error("load answered while halted");

    cover property (flash_start && cpu_halt);
    cover property (load_refused);
    cover property (store_refused);
    cover property (flash_start && flash_op == OP_LOCK_SET);
endmodule : bfg_guard_assertions

bind bfg_guard bfg_guard_assertions bfg_guard_assertions_i (
    .aclk, .aresetn, .store_valid, .store_req, .store_ready, .store_done,
    .store_refused, .load_valid, .load_req, .load_grant, .load_refused,
    .cpu_halt, .rww_read_block, .flash_start, .flash_op, .flash_done
);

/* File: test/bfg_guard_tb.sv */
// self-checking bench for the boot flash section guard
`timescale 1ns/1ps
module bfg_guard_tb
    import bfg_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h03;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, ext_lock_data = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, boot_size_fuses = 2'h3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic chip_erase = 1'b0, ext_lock_valid = 1'b0, store_valid = 1'b0, load_valid = 1'b0;
    bfg_store_s store_req = '0;
    bfg_load_s load_req = '0;
    logic store_ready, store_done, store_refused, load_grant, load_refused, cpu_halt;
    logic rww_read_block, irq_suppress, flash_start, flash_done;
    logic [14:0] flash_page;
    bfg_op_e flash_op;
    int miscompares = 0, checked = 0;

    always #2.5 aclk = ~aclk;

    bfg_guard bfg_guard_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_size_fuses,
        .chip_erase, .ext_lock_valid, .ext_lock_data, .store_valid, .store_req,
        .store_ready, .store_done, .store_refused, .load_valid, .load_req, .load_grant,
        .load_refused, .cpu_halt, .rww_read_block, .irq_suppress, .flash_start,
        .flash_op, .flash_page, .flash_done);
    bfg_flash_model bfg_flash_model_i (.aclk, .aresetn, .flash_start, .flash_op, .lat,
        .flash_done);

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_up(string what);
        chk(what, 32'h0, 32'h1);
        tally_and_finish();
    endtask : give_up

    // fuses are sampled at the first edge after release, so wait two edges
    task automatic do_reset(logic [1:0] f);
        aresetn <= 1'b0;
        boot_size_fuses <= f;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n == 50) give_up("bvalid");
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n == 50) give_up("rvalid");
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // r is {refused, start}; h is {halt seen, halt throughout} until done
    task automatic store(bfg_op_e op, logic [14:0] pc, tg, logic [3:0] d,
                         output logic [1:0] r, h);
        int n;
        chk("store_ready", store_ready, 1);
        store_req <= '{op, pc, tg, d};
        store_valid <= 1'b1;
        @(posedge aclk);
        store_valid <= 1'b0;
        @(posedge aclk);
        r = {store_refused, flash_start};
        h = {cpu_halt, cpu_halt};
        if (r == 2'b01 && op inside {OP_ERASE, OP_WRITE}) begin
            for (n = 0; n < 100 && store_done !== 1'b1; n++) begin
                @(posedge aclk);
                if (store_done !== 1'b1) h = {h[1] | cpu_halt, h[0] & cpu_halt};
            end
            if (n == 100) give_up("store_done");
        end
    endtask : store

    // r is {grant, refused}
    task automatic load(logic [14:0] pc, a, output logic [1:0] r);
        load_req <= '{pc, a};
        load_valid <= 1'b1;
        @(posedge aclk);
        load_valid <= 1'b0;
        @(posedge aclk);
        r = {load_grant, load_refused};
    endtask : load

    // outside programming: chip erase when ce is set, else lock bits
    task automatic pins(logic [3:0] d, logic ce);
        ext_lock_data <= d;
        ext_lock_valid <= ~ce;
        chip_erase <= ce;
        @(posedge aclk);
        ext_lock_valid <= 1'b0;
        chip_erase <= 1'b0;
        @(posedge aclk);
    endtask : pins

    initial begin
        logic [1:0] r, h;
        logic [31:0] d;
        do_reset(2'h3);
        axi_rd(REG_STATUS, d, r);
        chk("status", d, 32'h3f0);
        axi_rd(8'h08, d, r);
        chk("unmapped", r, RESP_DECERR);
        store(OP_ERASE, 15'h0100, 15'h0200, 4'hf, r, h);
        chk("app store", r, 2'b10);
        store(OP_ERASE, 15'h7000, 15'h7100, 4'hf, r, h);
        chk("below boot", r, 2'b10);
        store(OP_ERASE, 15'h7e00, 15'h6f80, 4'hf, r, h);
        chk("rww erase", {r, h}, 4'b0100);
        chk("busy", rww_read_block, 1);
        load(15'h7e00, 15'h0100, r);
        chk("rww read busy", r, 2'b01);
        load(15'h7e00, 15'h7100, r);
        chk("no_read_while_write_area read", r, 2'b10);
        axi_wr(REG_CTRL, 32'h1, r);
        chk("ctrl resp", {r, rww_read_block}, 3'b000);
        load(15'h7e00, 15'h0100, r);
        chk("rww read", r, 2'b10);
        lat <= 8'd30;
        load_req <= '{15'h7e00, 15'h7100};
        load_valid <= 1'b1;
        store(OP_WRITE, 15'h7e00, 15'h7000, 4'hf, r, h);
        chk("no_read_while_write_area write", {r, h}, 4'b0111);
        chk("halted load", {load_grant, load_refused}, 2'b00);
        chk("page", {flash_op, flash_page}, {OP_WRITE, 15'h7000});
        load_valid <= 1'b0;
        lat <= 8'd1;
        store(OP_LOCK_SET, 15'h7e00, 15'h0000, 4'b1110, r, h);
        store(OP_ERASE, 15'h7e00, 15'h0200, 4'hf, r, h);
        chk("app lock", r, 2'b10);
        store(OP_ERASE, 15'h7e00, 15'h7e80, 4'hf, r, h);
        chk("boot erase", {r, h}, 4'b0111);
        store(OP_LOCK_SET, 15'h7e00, 15'h0000, 4'b1101, r, h);
        load(15'h7e00, 15'h0100, r);
        chk("boot reads app", r, 2'b01);
        load(15'h0100, 15'h0100, r);
        chk("app reads app", r, 2'b10);
        axi_wr(REG_CTRL, 32'h2, r);
        chk("irq mask", {r, irq_suppress}, 3'b001);
        load(15'h0100, 15'h7e80, r);
        chk("app reads boot", r, 2'b10);
        pins(4'b1011, 1'b0);
        store(OP_ERASE, 15'h7e00, 15'h7e80, 4'hf, r, h);
        chk("boot lock", r, 2'b10);
        pins(4'b0111, 1'b0);
        load(15'h0100, 15'h7e80, r);
        chk("app reads boot", r, 2'b01);
        axi_rd(REG_STATUS, d, r);
        chk("locks set", d, 32'h300);
        pins(4'hf, 1'b1);
        axi_rd(REG_STATUS, d, r);
        chk("chip erase", d, 32'h3f0);
        store(OP_ERASE, 15'h7e00, 15'h0200, 4'hf, r, h);
        store(OP_BUF_LOAD, 15'h7e00, 15'h0200, 4'hf, r, h);
        chk("buf load clears", rww_read_block, 0);
        do_reset(2'h2);
        store(OP_ERASE, 15'h7bff, 15'h7100, 4'hf, r, h);
        chk("below boot 2", r, 2'b10);
        do_reset(2'h1);
        axi_rd(REG_STATUS, d, r);
        chk("fuse code 1", d, 32'h1f0);
        store(OP_ERASE, 15'h7800, 15'h7100, 4'hf, r, h);
        chk("mid boot", {r, h}, 4'b0111);
        do_reset(2'h0);
        axi_rd(REG_STATUS, d, r);
        chk("fuse code", d, 32'h0f0);
        store(OP_ERASE, 15'h7000, 15'h7100, 4'hf, r, h);
        chk("large boot", {r, h}, 4'b0111);
        tally_and_finish();
    end
endmodule : bfg_guard_tb
